// >>> mult_pkg.sv
/*
  shared constants and carriers of the registered 12 x 12 multiplier:
  widths, the layout of the sampled pin vector, register offsets, strobe
  bits, rounding weights and reset values.
  assumes nothing of its surroundings; compiled before every other file.
*/
package mult_pkg;

  // data widths
  localparam int OP_W   = 12;
  localparam int WORD_W = 12;
  localparam int PROD_W = 24;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // layout of the sampled pin vector
  localparam int PIN_X_LSB   = 0;
  localparam int PIN_Y_LSB   = 12;
  localparam int PIN_X_SEL   = 24;
  localparam int PIN_Y_SEL   = 25;
  localparam int PIN_ROUND   = 26;
  localparam int PIN_FT      = 27;
  localparam int PIN_RS      = 28;
  localparam int PIN_MSP_DIS = 29;
  localparam int PIN_LSP_DIS = 30;
  localparam int PIN_CLK_X   = 31;
  localparam int PIN_CLK_Y   = 32;
  localparam int PIN_CLK_L   = 33;
  localparam int PIN_CLK_M   = 34;
  localparam int PIN_W       = 35;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] REG_UPPER    = 4'h0;
  localparam logic [ADDR_W-1:0] REG_LOWER    = 4'h4;
  localparam logic [ADDR_W-1:0] REG_OPERANDS = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STROBE   = 4'hc;

  // bits of the strobe register
  localparam int STB_X   = 0;
  localparam int STB_Y   = 1;
  localparam int STB_LSP = 2;
  localparam int STB_MSP = 3;
  localparam int STB_W   = 4;

  // rounding weights: top bit of the lower word
  localparam logic [PROD_W-1:0] RND_ADD_RS0  = 24'h000400;
  localparam logic [PROD_W-1:0] RND_ADD_RS1  = 24'h000800;
  localparam logic [PROD_W-1:0] RND_ADD_NONE = 24'h000000;

  // reset values
  localparam logic [OP_W-1:0]   OP_RESET   = 12'h000;
  localparam logic [WORD_W-1:0] WORD_RESET = 12'h000;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h00000000;
  localparam logic [PIN_W-1:0]  PIN_RESET  = 35'h000000000;

  typedef struct packed {
    logic            signed_sel;
    logic [OP_W-1:0] value;
  } operand_s;

  typedef struct packed {
    logic [WORD_W-1:0] upper;
    logic [WORD_W-1:0] lower;
  } product_s;

endpackage

// >>> pin_sync.sv
/*
  two-stage synchroniser for a vector of pins, with a rising-edge pulse
  taken from the second stage.
  assumes every bit is a slow level relative to clk_in.
*/
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] pins_in,
  output logic      [W-1:0] level_out,
  output logic      [W-1:0] rise_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] stable_reg;
  logic [W-1:0] prev_reg;

  // first stage is read only by the second
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_reg   <= '0;
      stable_reg <= '0;
      prev_reg   <= '0;
    end else begin
      meta_reg   <= pins_in;
      stable_reg <= meta_reg;
      prev_reg   <= stable_reg;
    end
  end

  assign level_out = stable_reg;
  assign rise_out  = stable_reg & ~prev_reg;

endmodule

// >>> product_array.sv
/*
  combinational multiplier array: sign-selectable 12 x 12 product,
  positive rounding and the two output word formats.
  assumes registered operands and round control on its inputs.
*/
module product_array (
  input  mult_pkg::operand_s             x_in,
  input  mult_pkg::operand_s             y_in,
  input  wire logic                      round_in,
  input  wire logic                      rs_in,
  output mult_pkg::product_s             word_out,
  output logic [mult_pkg::PROD_W-1:0]    full_out
);

  logic signed [mult_pkg::OP_W:0]     x_ext;
  logic signed [mult_pkg::OP_W:0]     y_ext;
  logic signed [2*mult_pkg::OP_W+1:0] prod_wide;
  logic        [mult_pkg::PROD_W-1:0] rnd_add;
  logic        [mult_pkg::PROD_W-1:0] rounded;

  // bit 11 extends as sign only when the operand is two's complement
  assign x_ext = {x_in.signed_sel & x_in.value[mult_pkg::OP_W-1],
                  x_in.value};
  assign y_ext = {y_in.signed_sel & y_in.value[mult_pkg::OP_W-1],
                  y_in.value};
  assign prod_wide = x_ext * y_ext;
  assign full_out  = prod_wide[mult_pkg::PROD_W-1:0];

  // rounding always adds, so it biases upward
  assign rnd_add = !round_in ? mult_pkg::RND_ADD_NONE :
                   (rs_in ? mult_pkg::RND_ADD_RS1 : mult_pkg::RND_ADD_RS0);
  assign rounded = full_out + rnd_add;

  // rs low drops the duplicated sign, shifts the upper word up one bit and repeats bit 23 atop the lower
  assign word_out.upper = rs_in ? rounded[23:12] : rounded[22:11];
  assign word_out.lower = rs_in ? rounded[11:0]
                                : {rounded[23], rounded[10:0]};

endmodule

// >>> mult12_core.sv
/*
  registered 12 x 12 multiplier with separately clocked operand and
  product registers, feedthrough, right-shift format, positive rounding
  and per-word output enables; a small register port reads the product
  and operands and can strobe each load from software.
  assumes all device pins, its four clocks among them, are asynchronous
  levels far slower than clk_in; each is sampled through two flip-flops.
*/
// Chosen here: the address map and the address-and-strobe port.
module mult12_core (
  input  wire logic                          clk_in,
  input  wire logic                          rstn_in,
  input  wire logic [mult_pkg::OP_W-1:0]     x_operand_in,
  input  wire logic [mult_pkg::OP_W-1:0]     y_operand_in,
  input  wire logic                          x_signed_select_in,
  input  wire logic                          y_signed_select_in,
  input  wire logic                          round_request_in,
  input  wire logic                          output_feedthrough_in,
  input  wire logic                          right_shift_format_in,
  input  wire logic                          msp_output_disable_in,
  input  wire logic                          lsp_output_disable_in,
  input  wire logic                          x_operand_clock_in,
  input  wire logic                          y_operand_clock_in,
  input  wire logic                          lsp_clock_in,
  input  wire logic                          msp_clock_in,
  input  wire logic [mult_pkg::ADDR_W-1:0]   addr_in,
  input  wire logic [mult_pkg::DATA_W-1:0]   wdata_in,
  input  wire logic                          wr_in,
  input  wire logic                          rd_in,
  output logic      [mult_pkg::DATA_W-1:0]   rdata_out,
  output logic      [mult_pkg::WORD_W-1:0]   upper_product_word_out,
  output logic                               upper_oe_n_out,
  output logic      [mult_pkg::WORD_W-1:0]   lower_product_word_out,
  output logic                               lower_oe_n_out
);

  logic [mult_pkg::PIN_W-1:0]  pins_raw;
  logic [mult_pkg::PIN_W-1:0]  pins_s;
  logic [mult_pkg::PIN_W-1:0]  pins_rise;
  logic [mult_pkg::STB_W-1:0]  soft_stb_reg;
  logic                        or_clk_reg;
  logic                        or_clk_next;
  logic                        x_load;
  logic                        y_load;
  logic                        round_load;
  logic                        lsp_load;
  logic                        msp_load;
  logic                        ft_s;
  logic                        rs_s;
  mult_pkg::operand_s          x_reg;
  mult_pkg::operand_s          y_reg;
  logic                        round_reg;
  mult_pkg::product_s          arr_word;
  logic [mult_pkg::PROD_W-1:0] arr_full;
  logic [mult_pkg::WORD_W-1:0] upper_reg;
  logic [mult_pkg::WORD_W-1:0] lower_reg;

  // gather every pin into one vector so one synchroniser serves all
  assign pins_raw = {msp_clock_in, lsp_clock_in, y_operand_clock_in,
                     x_operand_clock_in, lsp_output_disable_in,
                     msp_output_disable_in, right_shift_format_in,
                     output_feedthrough_in, round_request_in,
                     y_signed_select_in, x_signed_select_in,
                     y_operand_in, x_operand_in};

  pin_sync #(
    .W (mult_pkg::PIN_W)
  ) u_pin_sync (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .pins_in   (pins_raw),
    .level_out (pins_s),
    .rise_out  (pins_rise)
  );

  assign ft_s = pins_s[mult_pkg::PIN_FT];
  assign rs_s = pins_s[mult_pkg::PIN_RS];

  // data and clocks share the same sync delay, so a sampled clock edge
  // meets the data that stood beside it at the pins
  assign x_load   = pins_rise[mult_pkg::PIN_CLK_X] |
                    soft_stb_reg[mult_pkg::STB_X];
  assign y_load   = pins_rise[mult_pkg::PIN_CLK_Y] |
                    soft_stb_reg[mult_pkg::STB_Y];
  assign lsp_load = pins_rise[mult_pkg::PIN_CLK_L] |
                    soft_stb_reg[mult_pkg::STB_LSP];
  assign msp_load = pins_rise[mult_pkg::PIN_CLK_M] |
                    soft_stb_reg[mult_pkg::STB_MSP];

  // round capture clock is the OR of both operand clocks; a clock that
  // idles high masks the other's edge, hence low-idle clocks are needed
  assign or_clk_next = pins_s[mult_pkg::PIN_CLK_X] |
                       pins_s[mult_pkg::PIN_CLK_Y];
  assign round_load  = (or_clk_next & ~or_clk_reg) |
                       soft_stb_reg[mult_pkg::STB_X] |
                       soft_stb_reg[mult_pkg::STB_Y];

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      or_clk_reg <= 1'b0;
    end else begin
      or_clk_reg <= or_clk_next;
    end
  end

  // x operand and its sign select load together, else hold
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      x_reg <= '{signed_sel: 1'b0, value: mult_pkg::OP_RESET};
    end else if (x_load) begin
      x_reg.value      <= pins_s[mult_pkg::PIN_X_LSB +: mult_pkg::OP_W];
      x_reg.signed_sel <= pins_s[mult_pkg::PIN_X_SEL];
    end
  end

  // y operand, independent of x so a constant may stay loaded
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      y_reg <= '{signed_sel: 1'b0, value: mult_pkg::OP_RESET};
    end else if (y_load) begin
      y_reg.value      <= pins_s[mult_pkg::PIN_Y_LSB +: mult_pkg::OP_W];
      y_reg.signed_sel <= pins_s[mult_pkg::PIN_Y_SEL];
    end
  end

  // round control register
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      round_reg <= 1'b0;
    end else if (round_load) begin
      round_reg <= pins_s[mult_pkg::PIN_ROUND];
    end
  end

  // array settles within one clk_in cycle of an operand load
  product_array u_array (
    .x_in     (x_reg),
    .y_in     (y_reg),
    .round_in (round_reg),
    .rs_in    (rs_s),
    .word_out (arr_word),
    .full_out (arr_full)
  );

  // product words load on their own clocks
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      upper_reg <= mult_pkg::WORD_RESET;
    end else if (msp_load) begin
      upper_reg <= arr_word.upper;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lower_reg <= mult_pkg::WORD_RESET;
    end else if (lsp_load) begin
      lower_reg <= arr_word.lower;
    end
  end

  // pin stage: feedthrough picks the array, disables follow their pins;
  // the output flop adds one clk_in of delay, no state of its own
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      upper_product_word_out <= mult_pkg::WORD_RESET;
      lower_product_word_out <= mult_pkg::WORD_RESET;
    end else begin
      upper_product_word_out <= ft_s ? arr_word.upper : upper_reg;
      lower_product_word_out <= ft_s ? arr_word.lower : lower_reg;
    end
  end

  // enables are low while driving; the host multiplexes the words
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      upper_oe_n_out <= 1'b1;
      lower_oe_n_out <= 1'b1;
    end else begin
      upper_oe_n_out <= pins_s[mult_pkg::PIN_MSP_DIS];
      lower_oe_n_out <= pins_s[mult_pkg::PIN_LSP_DIS];
    end
  end

  // software load strobes last one cycle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      soft_stb_reg <= '0;
    end else if (wr_in && addr_in == mult_pkg::REG_STROBE) begin
      soft_stb_reg <= wdata_in[mult_pkg::STB_W-1:0];
    end else begin
      soft_stb_reg <= '0;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= mult_pkg::DATA_ZERO;
    end else if (!rd_in) begin
      rdata_out <= mult_pkg::DATA_ZERO;
    end else if (addr_in == mult_pkg::REG_UPPER) begin
      rdata_out <= {20'h00000, upper_reg};
    end else if (addr_in == mult_pkg::REG_LOWER) begin
      rdata_out <= {20'h00000, lower_reg};
    end else if (addr_in == mult_pkg::REG_OPERANDS) begin
      rdata_out <= {6'h00, y_reg, x_reg};
    end else begin
      rdata_out <= mult_pkg::DATA_ZERO;  // strobe reg and holes read zero
    end
  end

  // independent reference product for the checks below
  logic signed [25:0] ref_prod;
  assign ref_prod = $signed({x_reg.signed_sel & x_reg.value[11], x_reg.value})
                  * $signed({y_reg.signed_sel & y_reg.value[11], y_reg.value});

  property p_full_product;
    @(posedge clk_in) disable iff (!rstn_in)
    arr_full == ref_prod[23:0];
  endproperty
  a_full_product: assert property (p_full_product)
    else $error("array product differs from reference");

  property p_x_hold;
    @(posedge clk_in) disable iff (!rstn_in)
    !x_load |=> $stable(x_reg);
  endproperty
  a_x_hold: assert property (p_x_hold)
    else $error("x operand changed without a load");

  property p_x_sel_capture;
    @(posedge clk_in) disable iff (!rstn_in)
    x_load |=> x_reg.signed_sel == $past(pins_s[mult_pkg::PIN_X_SEL]);
  endproperty
  a_x_sel_capture: assert property (p_x_sel_capture)
    else $error("x sign select not captured with operand");

  property p_round_capture;
    @(posedge clk_in) disable iff (!rstn_in)
    $rose(or_clk_next) |=> round_reg == $past(pins_s[mult_pkg::PIN_ROUND]);
  endproperty
  a_round_capture: assert property (p_round_capture)
    else $error("round control missed an or-clock edge");

  property p_msp_load;
    @(posedge clk_in) disable iff (!rstn_in)
    msp_load |=> upper_reg == $past(arr_word.upper);
  endproperty
  a_msp_load: assert property (p_msp_load)
    else $error("upper word did not load on its clock");

  property p_feedthrough;
    @(posedge clk_in) disable iff (!rstn_in)
    ft_s |=> lower_product_word_out == $past(arr_word.lower);
  endproperty
  a_feedthrough: assert property (p_feedthrough)
    else $error("feedthrough did not pass the array");

  property p_registered_view;
    @(posedge clk_in) disable iff (!rstn_in)
    !ft_s |=> upper_product_word_out == $past(upper_reg);
  endproperty
  a_registered_view: assert property (p_registered_view)
    else $error("outputs not showing registered word");

  property p_disable;
    @(posedge clk_in) disable iff (!rstn_in)
    pins_s[mult_pkg::PIN_LSP_DIS] |=> lower_oe_n_out;
  endproperty
  a_disable: assert property (p_disable)
    else $error("lower driver enabled while disabled");

  property p_shift_format;
    @(posedge clk_in) disable iff (!rstn_in)
    (rs_s && !round_reg) |-> arr_word.upper == ref_prod[23:12]
                             && arr_word.lower == ref_prod[11:0];
  endproperty
  a_shift_format: assert property (p_shift_format)
    else $error("right shift format wrong");

  property p_round_add;
    @(posedge clk_in) disable iff (!rstn_in)
    (!rs_s && round_reg) |->
      {arr_word.upper, arr_word.lower[10:0]} ==
      23'(ref_prod[22:0] + 23'h000400);
  endproperty
  a_round_add: assert property (p_round_add)
    else $error("round not added at lower word top bit");

  property p_y_hold;
    @(posedge clk_in) disable iff (!rstn_in)
    !y_load |=> $stable(y_reg);
  endproperty
  a_y_hold: assert property (p_y_hold)
    else $error("y operand changed without a load");

  property p_y_sel_capture;
    @(posedge clk_in) disable iff (!rstn_in)
    y_load |=> y_reg.signed_sel == $past(pins_s[mult_pkg::PIN_Y_SEL]);
  endproperty
  a_y_sel_capture: assert property (p_y_sel_capture)
    else $error("y sign select not captured with operand");

  property p_lsp_load;
    @(posedge clk_in) disable iff (!rstn_in)
    lsp_load |=> lower_reg == $past(arr_word.lower);
  endproperty
  a_lsp_load: assert property (p_lsp_load)
    else $error("lower word did not load on its clock");

  property p_enable;
    @(posedge clk_in) disable iff (!rstn_in)
    !pins_s[mult_pkg::PIN_MSP_DIS] |=> !upper_oe_n_out;
  endproperty
  a_enable: assert property (p_enable)
    else $error("upper driver off while enabled");

  // with the shift the weight lands on bit 11, the lower word's top
  property p_round_add_shift;
    @(posedge clk_in) disable iff (!rstn_in)
    (rs_s && round_reg) |->
      {arr_word.upper, arr_word.lower} ==
      24'(ref_prod[23:0] + mult_pkg::RND_ADD_RS1);
  endproperty
  a_round_add_shift: assert property (p_round_add_shift)
    else $error("shifted round not added at lower word top bit");

  c_signed_mult: cover property (@(posedge clk_in) disable iff (!rstn_in)
    x_reg.signed_sel && y_reg.signed_sel && msp_load);
  c_round_shift: cover property (@(posedge clk_in) disable iff (!rstn_in)
    round_reg && rs_s && lsp_load);
  c_mux_words: cover property (@(posedge clk_in) disable iff (!rstn_in)
    !upper_oe_n_out && lower_oe_n_out ##1 upper_oe_n_out && !lower_oe_n_out);

endmodule

// >>> host_model.sv
/*
  behavioural host on the pin side of the multiplier: drives operands,
  sign selects, the round request and the four device clocks on request.
  assumes clk_in is the bench clock and that the bench raises req_in for
  one cycle only while busy_out is low.
*/
module host_model (
  input  wire logic          clk_in,
  input  wire logic          rstn_in,
  input  wire logic          req_in,
  input  wire logic [1:0]    which_in,
  input  mult_pkg::operand_s op_in,
  input  wire logic          round_in,
  input  wire logic          slow_in,
  output logic               busy_out,
  output mult_pkg::operand_s x_out,
  output mult_pkg::operand_s y_out,
  output logic               round_out,
  output logic [3:0]         clocks_out  // x, y, lower, upper
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0]         w;
  mult_pkg::operand_s op;
  logic               slow;

  initial begin
    busy_out = 1'b0;
    x_out = '0;
    y_out = '0;
    round_out = 1'b0;
    clocks_out = 4'h0;
  end

  // one load: data first, then a clock pulse long enough to be sampled
  always @(posedge clk_in) begin
    if (req_in && rstn_in) begin
      w = which_in;
      op = op_in;
      slow = slow_in;
      busy_out <= 1'b1;
      if (w == 2'd0) x_out <= op;
      if (w == 2'd1) y_out <= op;
      if (w < 2'd2) round_out <= round_in;
      repeat (slow ? 6 : 3) @(posedge clk_in);
      clocks_out[w] <= 1'b1;
      repeat (slow ? 5 : 3) @(posedge clk_in);
      clocks_out <= 4'h0;  // idle low so the round capture is clean
      @(posedge clk_in);
      // hold time over: released pins show the inverse, never stale data
      if (w == 2'd0) x_out <= mult_pkg::operand_s'(~op);
      if (w == 2'd1) y_out <= mult_pkg::operand_s'(~op);
      if (w < 2'd2) round_out <= ~round_out;
      repeat (2) @(posedge clk_in);
      busy_out <= 1'b0;
    end
  end
endmodule

// >>> testbench.sv
/*
  self-checking bench of the 12 x 12 multiplier: pin-side loads through
  the host model, register port reads, feedthrough, output disables.
  assumes the design package is compiled first; expectations are queued
  by the driver and popped by a monitor when a result appears.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic               clk_in, rstn_in, ft, rs, dis_m, dis_l, wr, rd;
  logic               req, busy, round_pin, look, hrnd, hslow, rd_d;
  logic [1:0]         which;
  logic [3:0]         clks, addr;
  logic [31:0]        wdata, rdata;
  logic [11:0]        up_w, lo_w;
  logic               up_oe_n, lo_oe_n;
  mult_pkg::operand_s x_pin, y_pin, hop, ex, ey, nx, ny;
  mult_pkg::product_s w, last_w;
  int                 miscompares, n_tests, cycles;
  logic [31:0]        q_rd[$];
  logic [25:0]        q_w[$];

  mult12_core dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .x_operand_in(x_pin.value), .y_operand_in(y_pin.value),
    .x_signed_select_in(x_pin.signed_sel),
    .y_signed_select_in(y_pin.signed_sel), .round_request_in(round_pin),
    .output_feedthrough_in(ft), .right_shift_format_in(rs),
    .msp_output_disable_in(dis_m), .lsp_output_disable_in(dis_l),
    .x_operand_clock_in(clks[0]), .y_operand_clock_in(clks[1]),
    .lsp_clock_in(clks[2]), .msp_clock_in(clks[3]), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .upper_product_word_out(up_w), .upper_oe_n_out(up_oe_n),
    .lower_product_word_out(lo_w), .lower_oe_n_out(lo_oe_n));

  host_model host (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(req),
    .which_in(which), .op_in(hop), .round_in(hrnd), .slow_in(hslow),
    .busy_out(busy), .x_out(x_pin), .y_out(y_pin), .round_out(round_pin),
    .clocks_out(clks));

  // reference product with rounding and both output formats
  function automatic mult_pkg::product_s calc(mult_pkg::operand_s a, b,
                                              logic rnd, r);
    logic signed [25:0] sa, sb, sp;
    logic [23:0]        p;
    sa = a.signed_sel ? {{14{a.value[11]}}, a.value} : {14'h0, a.value};
    sb = b.signed_sel ? {{14{b.value[11]}}, b.value} : {14'h0, b.value};
    sp = sa * sb;
    p = sp[23:0] + (rnd ? (r ? mult_pkg::RND_ADD_RS1 : mult_pkg::RND_ADD_RS0)
                        : mult_pkg::RND_ADD_NONE);
    calc = {r ? p[23:12] : p[22:11],
            r ? p[11:0] : {p[23], p[10:0]}};
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check_rd(input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("BAD rdata exp %h got %h", e, g);
    end
  endtask

  task automatic check_word(input logic [25:0] e, g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("BAD words exp %h got %h", e, g);
    end
  endtask

  // bus cycles leave one idle cycle so no strobe is driven twice per step
  task automatic bus_read(input logic [3:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic look_at(input logic [25:0] e);
    q_w.push_back(e);
    look <= 1'b1;
    @(posedge clk_in);
    look <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic host_op(input logic [1:0] k, input mult_pkg::operand_s op,
                         input logic rnd, slow);
    int n;
    n = 0;
    req <= 1'b1;
    which <= k;
    hop <= op;
    hrnd <= rnd;
    hslow <= slow;
    @(posedge clk_in);
    req <= 1'b0;
    do begin
      @(posedge clk_in);
      n++;
    end while (busy && n < 100);
  endtask

  // full cycle: operands, format pins, both product clocks, then results
  task automatic multiply(input mult_pkg::operand_s a, b,
                          input logic rnd, r, lx, slow, input logic [1:0] d);
    if (lx) host_op(2'd0, a, rnd, slow);
    if (lx) ex = a;
    host_op(2'd1, b, rnd, slow);
    ey = b;
    rs <= r;
    dis_m <= d[1];
    dis_l <= d[0];
    host_op(2'd2, a, rnd, slow);
    host_op(2'd3, a, rnd, slow);
    repeat (8) @(posedge clk_in);
    w = calc(ex, ey, rnd, r);
    last_w = w;
    look_at({d[1], w.upper, d[0], w.lower});
    bus_read(mult_pkg::REG_UPPER, {20'h0, w.upper});
    bus_read(mult_pkg::REG_LOWER, {20'h0, w.lower});
    bus_read(mult_pkg::REG_OPERANDS, {6'h0, ey, ex});
  endtask

  // results are compared when they appear, oldest note first
  always @(posedge clk_in) begin
    rd_d <= rd;
    if (rd_d && q_rd.size() > 0) check_rd(q_rd.pop_front(), rdata);
    if (look && q_w.size() > 0)
      check_word(q_w.pop_front(), {up_oe_n, up_w, lo_oe_n, lo_w});
  end

  // hang guard, well above the fewer than one thousand cycles the run needs
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  initial begin
    logic rnd, r;
    {rstn_in, ft, rs, dis_m, dis_l, wr, rd, req, look, hrnd, hslow} = '0;
    {which, addr, wdata, hop, rd_d, miscompares, n_tests, cycles} = '0;
    void'($urandom(32'h0fab5f96));
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    // all four sign modes, extremes first, every third reuses x
    for (int i = 0; i < 12; i++) begin
      nx = {i[0], 12'($urandom())};
      ny = {i[1], 12'($urandom())};
      if (i < 4) nx.value = i[0] ? 12'h800 : 12'hfff;
      if (i < 4) ny.value = i[1] ? 12'h800 : 12'hfff;
      rnd = 1'($urandom());
      // a reused x keeps its old sign mode, so look at what x will hold
      r = ((i % 3 != 2 ? i[0] : ex.signed_sel) & i[1]) ? 1'($urandom())
                                                       : 1'b1;
      multiply(nx, ny, rnd, r, i % 3 != 2, i[2], i[1:0]);
    end
    // read-only and unmapped places
    bus_write(mult_pkg::REG_UPPER, $urandom());
    bus_read(mult_pkg::REG_UPPER, {20'h0, last_w.upper});
    bus_read(mult_pkg::REG_STROBE, mult_pkg::DATA_ZERO);
    bus_read(4'h2, mult_pkg::DATA_ZERO);
    // new operands without product clocks: only feedthrough shows them
    nx = {1'b1, 12'($urandom())};
    ny = {1'b1, 12'($urandom())};
    rnd = 1'($urandom());
    host_op(2'd0, nx, rnd, 1'b0);
    host_op(2'd1, ny, rnd, 1'b0);
    ex = nx;
    ey = ny;
    dis_m <= 1'b0;
    dis_l <= 1'b0;
    repeat (6) @(posedge clk_in);
    look_at({1'b0, last_w.upper, 1'b0, last_w.lower});
    ft <= 1'b1;
    repeat (6) @(posedge clk_in);
    w = calc(ex, ey, rnd, rs);
    look_at({1'b0, w.upper, 1'b0, w.lower});
    ft <= 1'b0;
    rs <= 1'b1;  // the reloaded x is unsigned
    // software strobes take the released pins, which now show the inverse
    bus_write(mult_pkg::REG_STROBE, 32'h1 << mult_pkg::STB_X);
    repeat (4) @(posedge clk_in);
    bus_write(mult_pkg::REG_STROBE,
              (32'h1 << mult_pkg::STB_LSP) | (32'h1 << mult_pkg::STB_MSP));
    repeat (8) @(posedge clk_in);
    ex = mult_pkg::operand_s'(~nx);
    w = calc(ex, ey, ~rnd, rs);
    look_at({1'b0, w.upper, 1'b0, w.lower});
    bus_read(mult_pkg::REG_OPERANDS, {6'h0, ey, ex});
    report_and_stop();
  end
endmodule
